// file: logic/path_monitor_pkg.sv
// Constants shared by the VC-4 path monitor
package path_monitor_pkg;
   localparam int          DATA_W          = 32;
   localparam int          ADDR_W          = 8;
   localparam int          CNT_W           = 16;
   localparam int          DEFECT_PERSIST  = 5;
   localparam int          TRACE_PERSIST   = 3;
   localparam logic [3:0]  ROW_LAST        = 4'h8;
   localparam logic [8:0]  COL_LAST        = 9'h104;
   localparam logic [3:0]  ROW_J1          = 4'h0;
   localparam logic [3:0]  ROW_B3          = 4'h1;
   localparam logic [3:0]  ROW_C2          = 4'h2;
   localparam logic [3:0]  ROW_G1          = 4'h3;
   localparam logic [7:0]  LABEL_AIS       = 8'hFF;
   localparam logic [7:0]  LABEL_UNEQ      = 8'h00;
   localparam logic [3:0]  REI_MAX         = 4'h8;
   localparam int          G1_RDI_BIT      = 3;
   localparam logic [1:0]  TPM_MONITORED   = 2'h1;
   localparam logic [ADDR_W-1:0] OFF_CTRL       = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_EXP_TRACE  = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_DEG_THRESH = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_DEFECTS    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_CAUSES     = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_ACC_TRACE  = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_NEAR_COUNT = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_FAR_COUNT  = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_SECONDS    = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 8'h28;
   localparam int          CTRL_TPM_LO     = 0;
   localparam int          CTRL_RDI_REP    = 2;
   localparam int          CTRL_SSF_REP    = 3;
   localparam int          CTRL_TIM_DIS    = 4;
   localparam logic [4:0]  CTRL_RESET      = 5'h00;
   localparam logic [CNT_W-1:0] DEG_THRESH_RESET = 16'h0100;
   localparam int          IRQ_W           = 6;
endpackage

// file: logic/path_monitor.sv
// Non-intrusive VC-4 path monitor with register port and interrupt
`timescale 1ns/1ps
`default_nettype none

module frame_persist
#(
   parameter int N = 5
)
(
   input  wire logic ref_clk,
   input  wire logic reset_n,
   input  wire logic strobe,
   input  wire logic cond,
   output logic      state_q
);
   logic [3:0] run_q;
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         {run_q, state_q} <= 5'h00;
      else if (strobe)
      begin
         if (cond == state_q)
            run_q <= 4'h0;
         else if (run_q == 4'(N - 1))
         begin
            run_q   <= 4'h0;
            state_q <= cond;
         end
         else
            run_q <= run_q + 4'h1;
      end
   end
endmodule // frame_persist

module path_monitor
   import path_monitor_pkg::*;
(
   input  wire logic                               ref_clk,
   input  wire logic                               reset_n,
   input  wire logic                               stream_clk,
   input  wire logic [7:0]                         stream_data,
   input  wire logic                               frame_start,
   input  wire logic                               incoming_server_fail,
   input  wire logic                               equipment_defect,
   input  wire logic                               one_second,
   input  wire logic [path_monitor_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [path_monitor_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                               reg_wr,
   input  wire logic                               reg_rd,
   output logic [path_monitor_pkg::DATA_W-1:0]     reg_rdata,
   output logic                                    irq,
   output logic                                    trail_fail_action,
   output logic                                    trail_degrade_action,
   output logic                                    unequipped_cause,
   output logic                                    trace_mismatch_cause,
   output logic                                    degraded_cause,
   output logic                                    remote_defect_cause,
   output logic                                    server_fail_cause,
   output logic [7:0]                              accepted_trace,
   output logic                                    near_defect_second,
   output logic                                    far_defect_second,
   output logic [path_monitor_pkg::CNT_W-1:0]      near_block_error_count,
   output logic [path_monitor_pkg::CNT_W-1:0]      far_block_error_count
);
   import path_monitor_pkg::*;

   // Two-stage synchronisers for the stream side
   logic       clk_s1_q, clk_s2_q, clk_s3_q;
   logic [7:0] data_s1_q, data_s2_q;
   logic       fs_s1_q, fs_s2_q, ssf_s1_q, ssf_s2_q;
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         {clk_s1_q, clk_s2_q, clk_s3_q, data_s1_q, data_s2_q, fs_s1_q, fs_s2_q, ssf_s1_q, ssf_s2_q} <= '0;
      else
      begin
         {clk_s3_q, clk_s2_q, clk_s1_q} <= {clk_s2_q, clk_s1_q, stream_clk};
         {data_s2_q, data_s1_q}         <= {data_s1_q, stream_data};
         {fs_s2_q, fs_s1_q}             <= {fs_s1_q, frame_start};
         {ssf_s2_q, ssf_s1_q}           <= {ssf_s1_q, incoming_server_fail};
      end
   end

   logic byte_stb;
   assign byte_stb = clk_s2_q & ~clk_s3_q;

   // Row and column position inside the VC-4
   logic [3:0] row_q;
   logic [8:0] col_q;
   logic       framed_q;
   logic [3:0] row_now;
   logic [8:0] col_now;
   assign row_now = fs_s2_q ? 4'h0 : row_q;
   assign col_now = fs_s2_q ? 9'h000 : col_q;
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         {row_q, col_q, framed_q} <= 14'h0000;
      else if (byte_stb)
      begin
         framed_q <= framed_q | fs_s2_q;
         col_q    <= (col_now == COL_LAST) ? 9'h000 : col_now + 9'h001;
         if (col_now == COL_LAST)
            row_q <= (row_now == ROW_LAST) ? 4'h0 : row_now + 4'h1;
         else
            row_q <= row_now;
      end
   end

   logic poh_stb, j1_stb, b3_stb, c2_stb, g1_stb;
   assign poh_stb = byte_stb & (framed_q | fs_s2_q) & (col_now == 9'h000);
   assign j1_stb  = poh_stb & (row_now == ROW_J1);
   assign b3_stb  = poh_stb & (row_now == ROW_B3);
   assign c2_stb  = poh_stb & (row_now == ROW_C2);
   assign g1_stb  = poh_stb & (row_now == ROW_G1);

   // Parity over the whole frame, held for the next frame's B3
   logic [7:0] par_acc_q, par_prev_q;
   logic       par_valid_q;
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         {par_acc_q, par_prev_q, par_valid_q} <= 17'h00000;
      else if (byte_stb)
      begin
         par_acc_q <= fs_s2_q ? data_s2_q : par_acc_q ^ data_s2_q;
         if (fs_s2_q)
         begin
            par_prev_q  <= par_acc_q;
            par_valid_q <= framed_q;
         end
      end
   end

   logic near_errored_block, far_errored_block, remote_bit;
   logic [3:0] rei_code;
   assign near_errored_block = b3_stb & par_valid_q & (data_s2_q != par_prev_q);
   assign rei_code           = data_s2_q[7:4];
   assign far_errored_block  = g1_stb & (rei_code != 4'h0) & (rei_code <= REI_MAX);
   assign remote_bit         = data_s2_q[G1_RDI_BIT];

   // Control registers
   logic [4:0]       ctrl_q;
   logic [7:0]       exp_trace_q;
   logic [CNT_W-1:0] deg_thresh_q;
   logic [IRQ_W-1:0] irq_status_q, irq_mask_q;
   logic monitoring_mode_on, remote_report_enable, server_fail_report_enable, trace_check_disable;
   logic [1:0] termination_point_mode;
   assign termination_point_mode    = ctrl_q[CTRL_TPM_LO+1:CTRL_TPM_LO];
   assign monitoring_mode_on        = (termination_point_mode == TPM_MONITORED);
   assign remote_report_enable      = ctrl_q[CTRL_RDI_REP];
   assign server_fail_report_enable = ctrl_q[CTRL_SSF_REP];
   assign trace_check_disable       = ctrl_q[CTRL_TIM_DIS];
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         {ctrl_q, exp_trace_q, deg_thresh_q, irq_mask_q} <= {CTRL_RESET, 8'h00, DEG_THRESH_RESET, IRQ_W'(0)};
      else if (reg_wr)
      begin
         case (reg_addr)
            OFF_CTRL:       ctrl_q       <= reg_wdata[4:0];
            OFF_EXP_TRACE:  exp_trace_q  <= reg_wdata[7:0];
            OFF_DEG_THRESH: deg_thresh_q <= reg_wdata[CNT_W-1:0];
            OFF_IRQ_MASK:   irq_mask_q   <= reg_wdata[IRQ_W-1:0];
            default:        ctrl_q       <= ctrl_q;
         endcase
      end
   end

   // Frame-persistent defect filters
   logic ais_raw, uneq_raw, rdi_raw, path_alarm_defect, block_detect;
   frame_persist #(.N(DEFECT_PERSIST)) u_ais (.ref_clk(ref_clk), .reset_n(reset_n), .strobe(c2_stb),
      .cond(data_s2_q == LABEL_AIS), .state_q(ais_raw));
   frame_persist #(.N(DEFECT_PERSIST)) u_uneq (.ref_clk(ref_clk), .reset_n(reset_n), .strobe(c2_stb),
      .cond(data_s2_q == LABEL_UNEQ), .state_q(uneq_raw));
   frame_persist #(.N(DEFECT_PERSIST)) u_rdi (.ref_clk(ref_clk), .reset_n(reset_n), .strobe(g1_stb),
      .cond(remote_bit), .state_q(rdi_raw));
   assign path_alarm_defect = ais_raw;
   assign block_detect      = ssf_s2_q | path_alarm_defect;

   // Trace acceptance after repeated identical bytes
   logic [7:0] received_trace_q;
   logic [1:0] trace_run_q;
   logic       trace_valid_q;
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         {received_trace_q, trace_run_q, accepted_trace, trace_valid_q} <= 19'h00000;
      else if (j1_stb)
      begin
         received_trace_q <= data_s2_q;
         if (data_s2_q != received_trace_q)
            trace_run_q <= 2'h0;
         else if (trace_run_q != 2'(TRACE_PERSIST - 2))
            trace_run_q <= trace_run_q + 2'h1;
         else
         begin
            accepted_trace <= data_s2_q;
            trace_valid_q  <= 1'b1;
         end
      end
   end

   logic unequipped_defect, trace_mismatch_defect, degraded_defect, remote_defect, deg_raw_q;
   assign unequipped_defect     = uneq_raw & ~block_detect;
   assign trace_mismatch_defect = trace_valid_q & (accepted_trace != exp_trace_q)
                                  & ~trace_check_disable & ~block_detect;
   assign degraded_defect       = deg_raw_q & ~block_detect;
   assign remote_defect         = rdi_raw & ~block_detect;

   // Consequent actions and correlated causes, registered
   logic [4:0] cause_d;
   always_comb
   begin
      cause_d[0] = unequipped_defect & monitoring_mode_on;
      cause_d[1] = trace_mismatch_defect & ~unequipped_defect & monitoring_mode_on;
      cause_d[2] = degraded_defect & ~trace_mismatch_defect & monitoring_mode_on;
      cause_d[3] = remote_defect & ~unequipped_defect & ~trace_mismatch_defect
                   & monitoring_mode_on & remote_report_enable;
      cause_d[4] = block_detect & monitoring_mode_on & server_fail_report_enable;
   end
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         trail_fail_action    <= 1'b0;
         trail_degrade_action <= 1'b0;
         {server_fail_cause, remote_defect_cause, degraded_cause, trace_mismatch_cause, unequipped_cause} <= 5'h00;
      end
      else
      begin
         trail_fail_action    <= block_detect | unequipped_defect | trace_mismatch_defect;
         trail_degrade_action <= degraded_defect;
         {server_fail_cause, remote_defect_cause, degraded_cause, trace_mismatch_cause, unequipped_cause} <= cause_d;
      end
   end

   // Per-second accumulation and capture
   logic [CNT_W-1:0] near_acc_q, far_acc_q, near_acc_d, far_acc_d;
   logic             near_ds_q, far_ds_q, near_ds_d, far_ds_d;
   assign near_acc_d = near_acc_q + CNT_W'(near_errored_block);
   assign far_acc_d  = far_acc_q + CNT_W'(far_errored_block);
   assign near_ds_d  = near_ds_q | trail_fail_action | equipment_defect;
   assign far_ds_d   = far_ds_q | remote_defect;
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         {near_acc_q, far_acc_q, near_block_error_count, far_block_error_count} <= '0;
         {near_ds_q, far_ds_q, near_defect_second, far_defect_second, deg_raw_q} <= 5'h00;
      end
      else if (one_second)
      begin
         near_block_error_count <= near_acc_d;
         far_block_error_count  <= far_acc_d;
         near_defect_second     <= near_ds_d;
         far_defect_second      <= far_ds_d;
         deg_raw_q  <= (near_acc_d >= deg_thresh_q);
         {near_acc_q, far_acc_q, near_ds_q, far_ds_q} <= '0;
      end
      else
      begin
         {near_acc_q, far_acc_q} <= {near_acc_d, far_acc_d};
         {near_ds_q, far_ds_q}   <= {near_ds_d, far_ds_d};
      end
   end

   // Sticky interrupt status: cause rises and second capture; set wins
   logic [4:0]       cause_prev_q;
   logic [IRQ_W-1:0] irq_set;
   assign irq_set = {one_second, cause_d & ~cause_prev_q};
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         {cause_prev_q, irq_status_q, irq} <= '0;
      else
      begin
         cause_prev_q <= cause_d;
         if (reg_wr && reg_addr == OFF_IRQ_STATUS)
            irq_status_q <= (irq_status_q & ~reg_wdata[IRQ_W-1:0]) | irq_set;
         else
            irq_status_q <= irq_status_q | irq_set;
         irq <= |(irq_status_q & irq_mask_q);
      end
   end

   // Read port, data one cycle after the strobe
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         reg_rdata <= '0;
      else if (reg_rd)
      begin
         case (reg_addr)
            OFF_CTRL:       reg_rdata <= DATA_W'(ctrl_q);
            OFF_EXP_TRACE:  reg_rdata <= DATA_W'(exp_trace_q);
            OFF_DEG_THRESH: reg_rdata <= DATA_W'(deg_thresh_q);
            OFF_DEFECTS:    reg_rdata <= DATA_W'({trail_degrade_action, trail_fail_action, remote_defect,
                                        degraded_defect, trace_mismatch_defect, unequipped_defect, path_alarm_defect});
            OFF_CAUSES:     reg_rdata <= DATA_W'({server_fail_cause, remote_defect_cause, degraded_cause,
                                        trace_mismatch_cause, unequipped_cause});
            OFF_ACC_TRACE:  reg_rdata <= DATA_W'(accepted_trace);
            OFF_NEAR_COUNT: reg_rdata <= DATA_W'(near_block_error_count);
            OFF_FAR_COUNT:  reg_rdata <= DATA_W'(far_block_error_count);
            OFF_SECONDS:    reg_rdata <= DATA_W'({far_defect_second, near_defect_second});
            OFF_IRQ_STATUS: reg_rdata <= DATA_W'(irq_status_q);
            OFF_IRQ_MASK:   reg_rdata <= DATA_W'(irq_mask_q);
            default:        reg_rdata <= '0;
         endcase
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_b3_near_count: assert property (near_errored_block && !one_second |=> near_acc_q == $past(near_acc_q) + 1'b1)
      else $error("B3 mismatch not counted");
   a_rei_decode: assert property (far_errored_block |-> g1_stb && rei_code inside {[4'h1:4'h8]})
      else $error("REI decode wrong");
   a_ais_rise: assert property ($rose(path_alarm_defect) |-> $past(c2_stb && data_s2_q == LABEL_AIS))
      else $error("Path alarm set without all-ones label");
   a_fail_action: assert property (trail_fail_action == $past(block_detect | unequipped_defect | trace_mismatch_defect))
      else $error("Trail fail mismatch");
   a_tim_masked: assert property (trace_check_disable |-> !trace_mismatch_defect)
      else $error("Mismatch while disabled");
   a_uneq_tim_cause: assert property (trace_mismatch_cause |-> $past(!unequipped_defect && monitoring_mode_on))
      else $error("Mismatch cause wrongly reported");
   a_deg_cause: assert property (degraded_cause |-> $past(degraded_defect && !trace_mismatch_defect))
      else $error("Degraded cause wrongly reported");
   a_rdi_cause: assert property (remote_defect_cause |-> $past(remote_report_enable && remote_defect))
      else $error("Remote cause wrongly reported");
   a_ssf_cause: assert property (server_fail_cause |-> $past(block_detect && server_fail_report_enable))
      else $error("Server fail cause wrongly reported");
   a_second_capture: assert property (one_second |=> near_block_error_count == $past(near_acc_d) && near_acc_q == 0)
      else $error("Second capture wrong");
   a_near_second: assert property (one_second && equipment_defect |=> near_defect_second)
      else $error("Near defect second missed");
   a_mon_gate: assert property (!monitoring_mode_on ##1 !monitoring_mode_on |-> !unequipped_cause && !degraded_cause)
      else $error("Cause while not monitoring");

   c_ais_set: cover property ($rose(path_alarm_defect));
   c_b3_error: cover property (near_errored_block);
   c_irq: cover property ($rose(irq));
   c_capture: cover property (one_second && near_acc_q != 0);
endmodule // path_monitor
`default_nettype wire

// file: testbench/vc4_stream_source.sv
// Behavioural VC-4 byte stream source for the path monitor bench
`timescale 1ns/1ps
`default_nettype none
module vc4_stream_source
(
   input  wire logic       run,
   input  wire logic [7:0] trace_byte,
   input  wire logic [7:0] label_byte,
   output logic            stream_clk,
   output logic [7:0]      stream_data,
   output logic            frame_start,
   output int              frame_no,
   output int              byte_no
);
   localparam int FRAME_BYTES = 2349;
   logic [3:0] rei_tab [5] = '{4'h0, 4'h8, 4'h9, 4'h1, 4'hF};
   logic [7:0] par_q;
   logic [7:0] acc;
   logic [7:0] b;

   initial
   begin
      stream_clk = 1'b0;
      stream_data = 8'h00;
      frame_start = 1'b0;
      frame_no = 0;
      byte_no = 0;
      par_q = 8'h00;
      acc = 8'h00;
      wait (run);
      forever
      begin
         for (int i = 0; i < FRAME_BYTES; i++)
         begin
            byte_no = i;
            if (i == 0)
               b = trace_byte;
            else if (i == 261)
               b = par_q ^ ((frame_no == 2 || frame_no == 3) ? 8'h10 : 8'h00);
            else if (i == 522)
               b = label_byte;
            else if (i == 783)
               b = {rei_tab[frame_no % 5], 4'hD};
            else
               b = i[7:0] ^ frame_no[7:0];
            // Data moves on the falling edge, stable around the rise
            stream_data = b;
            frame_start = (i == 0);
            acc = (i == 0) ? b : (acc ^ b);
            #40 stream_clk = 1'b1;
            #40 stream_clk = 1'b0;
         end
         par_q = acc;
         frame_no++;
      end
   end
endmodule // vc4_stream_source
`default_nettype wire

// file: testbench/tb_path_monitor.sv
// Self-checking bench for the VC-4 path monitor
`timescale 1ns/1ps
`default_nettype none
module tb_path_monitor;
   import path_monitor_pkg::*;
   logic ref_clk, reset_n, run, stream_clk, frame_start, incoming_server_fail;
   logic equipment_defect, one_second, reg_wr, reg_rd, irq;
   logic trail_fail_action, trail_degrade_action, unequipped_cause, trace_mismatch_cause;
   logic degraded_cause, remote_defect_cause, server_fail_cause, near_defect_second, far_defect_second;
   logic [7:0]        stream_data, accepted_trace, trace_b, label_b;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, v;
   logic [CNT_W-1:0]  near_block_error_count, far_block_error_count;
   int                frame_no, byte_no, error_cnt, comparisons, cyc;
   wire [6:0] st = {trail_fail_action, trail_degrade_action, unequipped_cause, trace_mismatch_cause,
                    degraded_cause, remote_defect_cause, server_fail_cause};

   path_monitor path_monitor_i (.ref_clk, .reset_n, .stream_clk, .stream_data, .frame_start,
      .incoming_server_fail, .equipment_defect, .one_second, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq, .trail_fail_action, .trail_degrade_action, .unequipped_cause,
      .trace_mismatch_cause, .degraded_cause, .remote_defect_cause, .server_fail_cause, .accepted_trace,
      .near_defect_second, .far_defect_second, .near_block_error_count, .far_block_error_count);
   vc4_stream_source vc4_stream_source_i (.run, .trace_byte(trace_b), .label_byte(label_b), .stream_clk,
      .stream_data, .frame_start, .frame_no, .byte_no);

   always #5 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         error_cnt++;
         summarize();
      end
   end

   task summarize();
      $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task wait_st(input logic [6:0] exp, input int lim);
      int n;
      n = 0;
      #1;
      while (st !== exp && n < lim)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk("status", {25'h0, exp}, {25'h0, st});
   endtask

   task wait_pos(input int f, input int b);
      int n;
      n = 0;
      while ((frame_no < f || (frame_no == f && byte_no < b)) && n < 70000)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk("stream_pos", 32'h1, {31'h0, n < 70000});
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Equipment defect is high in the cycle before and with the pulse
   task sec(input logic eq);
      @(posedge ref_clk);
      equipment_defect <= eq;
      @(posedge ref_clk);
      one_second <= 1'b1;
      @(posedge ref_clk);
      one_second <= 1'b0;
      equipment_defect <= 1'b0;
      @(posedge ref_clk);
      #1;
   endtask

   task t_reset();
      wait_st(7'h00, 1);
      rd(OFF_CTRL, v);
      chk("ctrl", 32'h0, v);
      rd(OFF_DEG_THRESH, v);
      chk("deg_thresh", 32'h100, v);
      rd(8'h3C, v);
      chk("unmapped", 32'h0, v);
   endtask

   task t_server_fail();
      wr(OFF_IRQ_MASK, 32'h3F);
      wr(OFF_CTRL, 32'h1D);
      @(posedge ref_clk);
      incoming_server_fail <= 1'b1;
      wait_st(7'h41, 20);
      rd(OFF_DEFECTS, v);
      chk("defects", 32'h20, v);
      rd(OFF_IRQ_STATUS, v);
      chk("irq_status", 32'h10, v);
      chk("irq", 32'h1, {31'h0, irq});
      wr(OFF_IRQ_MASK, 32'h0);
      repeat (2) @(posedge ref_clk);
      #1 chk("irq", 32'h0, {31'h0, irq});
      wr(OFF_IRQ_STATUS, 32'h3F);
      wr(OFF_IRQ_MASK, 32'h3F);
      repeat (2) @(posedge ref_clk);
      #1 chk("irq", 32'h0, {31'h0, irq});
      wr(OFF_CTRL, 32'h1E);
      wait_st(7'h40, 20);
      wr(OFF_CTRL, 32'h1D);
      wait_st(7'h41, 20);
      wr(OFF_CTRL, 32'h15);
      wait_st(7'h40, 20);
      @(posedge ref_clk);
      incoming_server_fail <= 1'b0;
      wait_st(7'h00, 20);
   endtask

   task t_stream();
      wr(OFF_EXP_TRACE, 32'h5A);
      wr(OFF_DEG_THRESH, 32'h2);
      wr(OFF_CTRL, 32'h1D);
      sec(1'b0);
      run <= 1'b1;
      wait_pos(3, 800);
      sec(1'b1);
      chk("near_count", 32'h2, {16'h0, near_block_error_count});
      chk("far_count", 32'h2, {16'h0, far_block_error_count});
      chk("near_ds", 32'h1, {31'h0, near_defect_second});
      chk("far_ds", 32'h0, {31'h0, far_defect_second});
      chk("trace", 32'h5A, {24'h0, accepted_trace});
      rd(OFF_NEAR_COUNT, v);
      chk("near_reg", 32'h2, v);
      wait_st(7'h24, 10);
      wait_pos(4, 800);
      wait_st(7'h26, 200);
      rd(OFF_DEFECTS, v);
      chk("defects", 32'h58, v);
      sec(1'b0);
      chk("near_count", 32'h0, {16'h0, near_block_error_count});
      chk("far_count", 32'h0, {16'h0, far_block_error_count});
      chk("near_ds", 32'h0, {31'h0, near_defect_second});
      chk("far_ds", 32'h1, {31'h0, far_defect_second});
      wait_st(7'h02, 10);
   endtask

   task t_trace();
      wr(OFF_CTRL, 32'h0D);
      wr(OFF_EXP_TRACE, 32'hA5);
      wait_st(7'h48, 20000);
      wr(OFF_CTRL, 32'h1D);
      wait_st(7'h02, 20000);
   endtask

   initial
   begin
      ref_clk = 1'b0;
      reset_n = 1'b0;
      run = 1'b0;
      incoming_server_fail = 1'b0;
      equipment_defect = 1'b0;
      one_second = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      trace_b = 8'h5A;
      label_b = 8'h13;
      error_cnt = 0;
      comparisons = 0;
      cyc = 0;
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset();
      t_server_fail();
      t_stream();
      t_trace();
      summarize();
   end
endmodule // tb_path_monitor
`default_nettype wire
